/* core/pix_stream_fifo.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : Small synchronous FIFO between imaging array and grabber
// Assumes : DEPTH is a power of two
// Notes   : in_ready is registered so the upstream sees a flop
//////////////////////////////////////////////////////////////////////////////
module pix_stream_fifo #(
    parameter int WIDTH = 7,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             in_valid,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  in_ready,
    output logic                  out_valid,
    output logic [WIDTH-1:0]      out_data,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_q [DEPTH];    // Storage
    logic [AW-1:0]    wr_q, wr_d;       // Write pointer
    logic [AW-1:0]    rd_q, rd_d;       // Read pointer
    logic [AW:0]      cnt_q, cnt_d;     // Fill level
    logic             rdy_q, rdy_d;     // Registered space flag
    logic             push, pop;

    assign push      = in_valid && rdy_q;
    assign pop       = out_valid && out_ready;
    assign out_valid = (cnt_q != '0);
    assign out_data  = mem_q[rd_q];
    assign in_ready  = rdy_q;

    // Pointer and level update
    always_comb
    begin
        wr_d  = push ? wr_q + AW'(1) : wr_q;
        rd_d  = pop ? rd_q + AW'(1) : rd_q;
        cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
        // Conservative: full as soon as the level reaches depth
        rdy_d = (cnt_d < (AW+1)'(DEPTH));
    end

    // Registers only
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
            rdy_q <= 1'b1;
        end
        else
        begin
            wr_q  <= wr_d;
            rd_q  <= rd_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
        end
    end

    // Data storage, no reset needed
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q] <= in_data;
        end
    end

    a_no_overflow : assert property (@(posedge clk) disable iff (!rst_n)
        cnt_q <= (AW+1)'(DEPTH)) else $error("FIFO level above depth");

endmodule // pix_stream_fifo

/* core/pixgrab_top.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : Frame grabber, exposure control and frame timer of the sensor
// Assumes : Register strobes come from the serial port, one cycle each
// Notes   : Array pixels arrive in pixel-number order through a FIFO
//////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Pixel register: SOF, valid, six-bit intensity
// - Intensity spans 0 black to 63 white
// - Any pixel write restarts at pixel 1
// - Each read that delivers a held pixel advances pixel number
// - Wraps to pixel 1 after 324
// - SOF set only for pixel 1
// - Valid flag shows undelivered captured pixel
// - At most one pixel per frame
// - Any pixel access arms grabber until read
// - Numbering column by column, 18 per column
// - AGC keeps brightest pixel mid fifties
// - Sixteen-bit exposure, reset 0x0100, two bytes
// - Exposure steps one sixteenth, once per frame
// - Exposure capped at frame clocks minus 3476, or at 16 for frames of 3492 clocks or fewer
// - Frame preload register, reset 0xC2
// - Frame counter counts up, ends on overflow
// - Forced awake bit; else sleep after idle
module pixgrab_top
    import pixgrab_pkg::*;
#(
    parameter int SLEEP_COUNT = SLEEP_CYCLES,
    parameter int FIFO_DEPTH  = STREAM_DEPTH
) (
    input  wire logic       SYS_CLK,
    input  wire logic       RESET_N,
    input  wire logic [7:0] REG_ADDR,
    input  wire logic [7:0] REG_WDATA,
    input  wire logic       REG_WR,
    input  wire logic       REG_RD,
    output logic [7:0]      REG_RDATA,
    input  wire logic       PIX_VALID,
    input  wire logic       PIX_FIRST,
    input  wire logic [5:0] PIX_DATA,
    output logic            PIX_READY,
    input  wire logic       FORCED_AWAKE,
    input  wire logic       MOTION,
    output logic            AWAKE,
    output logic            FRAME_END,
    output logic [15:0]     SHUTTER
);
    //////////////////////////////////////////////////////////////////////////
    // Declarations
    //////////////////////////////////////////////////////////////////////////
    pix_word_s   in_word;                   // Word into FIFO
    pix_word_s   out_word;                  // Word out of FIFO
    logic        fifo_valid;                // FIFO holds a word
    logic        fifo_ready;                // Grabber drains
    logic        pop;                       // Word taken this cycle
    logic [8:0]  word_idx;                  // Pixel number of popped word

    grab_state_e st_q, st_d;                // Grabber state
    logic [8:0]  want_q, want_d;            // Pixel number to capture
    logic [8:0]  idx_q, idx_d;              // Last popped pixel number
    logic [5:0]  held_q, held_d;            // Captured intensity
    logic [5:0]  fmax_q, fmax_d;            // Running frame maximum
    logic [5:0]  lmax_q, lmax_d;            // Last complete frame maximum

    logic [15:0] shut_q, shut_d;            // Exposure in clocks
    logic [7:0]  low_snap_q, low_snap_d;    // Low byte snapshot
    logic [7:0]  pre_q, pre_d;              // Frame preload upper byte
    logic [15:0] fcnt_q, fcnt_d;            // Frame counter
    logic        fend_q, fend_d;            // Frame end pulse
    logic [7:0]  rdata_q, rdata_d;          // Read data register
    logic [31:0] idle_q, idle_d;            // Cycles without motion
    logic        awake_q, awake_d;          // Awake state

    logic        pix_rd, pix_wr, pix_acc;   // Pixel register strobes
    logic        deliver;                   // Read hands out held pixel
    logic [16:0] frame_clks;                // Clocks per frame
    logic [15:0] shut_lim;                  // Exposure ceiling
    logic [15:0] step;                      // One sixteenth of exposure
    logic [16:0] shut_up;                   // Raised exposure, unclamped

    assign pix_rd  = REG_RD && (REG_ADDR == ADDR_PIXEL);
    assign pix_wr  = REG_WR && (REG_ADDR == ADDR_PIXEL);
    assign pix_acc = pix_rd || pix_wr;
    assign deliver = pix_rd && (st_q == GRAB_HOLD);

    //////////////////////////////////////////////////////////////////////////
    // Pixel stream buffer
    //////////////////////////////////////////////////////////////////////////
    assign in_word.first = PIX_FIRST;
    assign in_word.level = PIX_DATA;

    // Holding a pixel stalls the drain, so the array sees back-pressure
    assign fifo_ready = (st_q != GRAB_HOLD);
    assign pop        = fifo_valid && fifo_ready;

    pix_stream_fifo #(
        .WIDTH ($bits(pix_word_s)),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (SYS_CLK),
        .rst_n     (RESET_N),
        .in_valid  (PIX_VALID),
        .in_data   (in_word),
        .in_ready  (PIX_READY),
        .out_valid (fifo_valid),
        .out_data  (out_word),
        .out_ready (fifo_ready)
    );

    // Stream order is column by column, 18 rows each
    assign word_idx = out_word.first ? FIRST_PIXEL : idx_q + 9'h001;

    //////////////////////////////////////////////////////////////////////////
    // Frame grabber
    //////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        st_d   = st_q;
        want_d = want_q;
        idx_d  = pop ? word_idx : idx_q;
        held_d = held_q;
        fmax_d = fmax_q;
        lmax_d = lmax_q;
        // Frame maximum feeds the exposure loop
        if (pop)
        begin
            if (out_word.first)
            begin
                lmax_d = fmax_q;
                fmax_d = out_word.level;
            end
            else if (out_word.level > fmax_q)
            begin
                fmax_d = out_word.level;
            end
        end
        // A pixel write takes priority over a same-cycle capture
        if (pix_wr)
        begin
            want_d = FIRST_PIXEL;
            st_d   = GRAB_WAIT_SOF;
        end
        // A read while already armed must not restart the search, or a
        // polling host would never see any pixel but the first
        else if (pix_rd && ((st_q == GRAB_HOLD) || (st_q == GRAB_IDLE)))
        begin
            if (deliver)
            begin
                // Advance and wrap after the last pixel
                want_d = (want_q == NUM_PIXELS) ? FIRST_PIXEL
                                                : want_q + 9'h001;
            end
            st_d = GRAB_WAIT_SOF;
        end
        else
        begin
            case (st_q)
                GRAB_IDLE:
                begin
                    st_d = GRAB_IDLE;
                end
                // A fresh frame start ensures one pixel per frame
                GRAB_WAIT_SOF:
                begin
                    if (pop && out_word.first)
                    begin
                        st_d = GRAB_SEEK;
                        if (want_q == FIRST_PIXEL)
                        begin
                            held_d = out_word.level;
                            st_d   = GRAB_HOLD;
                        end
                    end
                end
                GRAB_SEEK:
                begin
                    if (pop && (word_idx == want_q))
                    begin
                        held_d = out_word.level;
                        st_d   = GRAB_HOLD;
                    end
                    else if (pop && out_word.first)
                    begin
                        // Wanted pixel missing; retry in this frame
                        st_d = GRAB_SEEK;
                    end
                end
                // Held indefinitely until the host reads it or writes the pixel register
                GRAB_HOLD:
                begin
                    st_d = GRAB_HOLD;
                end
                default:
                begin
                    st_d = GRAB_IDLE;
                end
            endcase
        end
    end

    // Grabber registers
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            st_q   <= GRAB_IDLE;
            want_q <= FIRST_PIXEL;
            idx_q  <= '0;
            held_q <= '0;
            fmax_q <= '0;
            lmax_q <= '0;
        end
        else
        begin
            st_q   <= st_d;
            want_q <= want_d;
            idx_q  <= idx_d;
            held_q <= held_d;
            fmax_q <= fmax_d;
            lmax_q <= lmax_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Frame timer and exposure control
    //////////////////////////////////////////////////////////////////////////
    assign frame_clks = FRAME_SPAN - {1'b0, pre_q, 8'h00};
    // Very short frames leave only the floor exposure
    assign shut_lim   = (frame_clks > (EXP_MARGIN + {1'b0, EXP_FLOOR}))
                        ? 16'(frame_clks - EXP_MARGIN) : EXP_FLOOR;
    assign step       = shut_q >> AGC_SHIFT;
    assign shut_up    = {1'b0, shut_q} + {1'b0, step};

    always_comb
    begin
        fend_d = 1'b0;
        fcnt_d = fcnt_q + 16'h0001;
        shut_d = shut_q;
        pre_d  = REG_WR && (REG_ADDR == ADDR_FRAME_PRE) ? REG_WDATA : pre_q;
        if (fcnt_q == FRAME_TOP)
        begin
            // Preload sampled only here, current frame untouched
            fcnt_d = {pre_q, 8'h00};
            fend_d = 1'b1;
            // One step per frame toward the brightness window
            if (lmax_q > AGC_HIGH)
            begin
                shut_d = shut_q - step;
            end
            else if (lmax_q < AGC_LOW)
            begin
                shut_d = (shut_up > {1'b0, shut_lim}) ? shut_lim : 16'(shut_up);
            end
            if (shut_d > shut_lim)
            begin
                shut_d = shut_lim;
            end
        end
    end

    // Timer registers
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            fcnt_q <= {PRELOAD_RESET, 8'h00};
            fend_q <= 1'b0;
            shut_q <= EXPOSURE_RESET;
            pre_q  <= PRELOAD_RESET;
        end
        else
        begin
            fcnt_q <= fcnt_d;
            fend_q <= fend_d;
            shut_q <= shut_d;
            pre_q  <= pre_d;
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Register read path and sleep timer
    //////////////////////////////////////////////////////////////////////////
    always_comb
    begin
        rdata_d    = rdata_q;
        low_snap_d = low_snap_q;
        if (REG_RD)
        begin
            case (REG_ADDR)
                ADDR_PIXEL:
                begin
                    rdata_d[SOF_BIT]   = (want_q == FIRST_PIXEL);
                    rdata_d[VALID_BIT] = (st_q == GRAB_HOLD);
                    rdata_d[5:0]       = held_q & PIXEL_MAX_VAL;
                end
                ADDR_EXP_HIGH:
                begin
                    rdata_d    = shut_q[15:8];
                    low_snap_d = shut_q[7:0];
                end
                ADDR_EXP_LOW:
                begin
                    rdata_d = low_snap_q;
                end
                ADDR_FRAME_PRE:
                begin
                    rdata_d = pre_q;
                end
                default:
                begin
                    rdata_d = 8'h00;
                end
            endcase
        end
        // Sleep after a quiet spell unless held awake
        awake_d = 1'b1;
        idle_d  = 32'h0000_0000;
        if (!FORCED_AWAKE && !MOTION)
        begin
            idle_d  = (idle_q >= 32'(SLEEP_COUNT)) ? idle_q : idle_q + 32'h0000_0001;
            awake_d = (idle_d < 32'(SLEEP_COUNT));
        end
    end

    // Read and sleep registers
    always_ff @(posedge SYS_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            rdata_q    <= 8'h00;
            low_snap_q <= EXPOSURE_RESET[7:0];
            idle_q     <= 32'h0000_0000;
            awake_q    <= 1'b1;
        end
        else
        begin
            rdata_q    <= rdata_d;
            low_snap_q <= low_snap_d;
            idle_q     <= idle_d;
            awake_q    <= awake_d;
        end
    end

    assign REG_RDATA = rdata_q;
    assign AWAKE     = awake_q;
    assign FRAME_END = fend_q;
    assign SHUTTER   = shut_q;

    //////////////////////////////////////////////////////////////////////////
    // Assertions
    //////////////////////////////////////////////////////////////////////////
    sequence s_pix_write;
        REG_WR && (REG_ADDR == ADDR_PIXEL);
    endsequence

    sequence s_deliver_mid;
        REG_RD && (REG_ADDR == ADDR_PIXEL) && (st_q == GRAB_HOLD)
            && (want_q != NUM_PIXELS);
    endsequence

    a_write_restart : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_pix_write |=> (want_q == FIRST_PIXEL) && (st_q == GRAB_WAIT_SOF))
        else $error("Pixel write did not restart at pixel one");

    a_read_advance : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        s_deliver_mid |=> want_q == $past(want_q) + 9'h001)
        else $error("Delivered read did not advance pixel number");

    a_pixel_wrap : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (deliver && want_q == NUM_PIXELS) |=> want_q == FIRST_PIXEL)
        else $error("Pixel number did not wrap after last pixel");

    a_sof_flag : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        pix_rd |=> REG_RDATA[SOF_BIT] == ($past(want_q) == FIRST_PIXEL))
        else $error("Start flag does not match pixel one");

    a_valid_flag : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        pix_rd |=> REG_RDATA[VALID_BIT] == $past(st_q == GRAB_HOLD))
        else $error("Valid flag does not match held pixel");

    a_arm_access : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (pix_wr || (pix_rd && (st_q == GRAB_HOLD || st_q == GRAB_IDLE)))
            |=> st_q == GRAB_WAIT_SOF ##1 st_q != GRAB_HOLD || $past(pop))
        else $error("Access did not arm the grabber");

    a_exp_once : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (fcnt_q != FRAME_TOP) |=> $stable(shut_q))
        else $error("Exposure changed outside frame end");

    a_exp_limit : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        $rose(fend_q) |-> shut_q <= $past(shut_lim))
        else $error("Exposure above ceiling");

    a_frame_reload : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (fcnt_q == FRAME_TOP) |=> fend_q && fcnt_q == {$past(pre_q), 8'h00})
        else $error("Frame counter reload wrong");

    a_low_snapshot : assert property (@(posedge SYS_CLK) disable iff (!RESET_N)
        (REG_RD && REG_ADDR == ADDR_EXP_HIGH) ##1 (REG_RD && REG_ADDR == ADDR_EXP_LOW)
            |=> REG_RDATA == $past(shut_q[7:0], 2))
        else $error("Low exposure byte not coherent");

endmodule // pixgrab_top

/* inc/pixgrab_pkg.sv */
//////////////////////////////////////////////////////////////////////////////
// Purpose : Shared constants and carrier types for the pixel grabber block
// Assumes : 20 MHz system clock, byte-wide register port
// Notes   : Every offset, reset value and timing count lives here
//////////////////////////////////////////////////////////////////////////////
package pixgrab_pkg;

    // Register offsets
    localparam logic [7:0]  ADDR_PIXEL      = 8'h48;
    localparam logic [7:0]  ADDR_EXP_HIGH   = 8'h49;
    localparam logic [7:0]  ADDR_EXP_LOW    = 8'h4A;
    localparam logic [7:0]  ADDR_FRAME_PRE  = 8'h4B;

    // Reset values
    localparam logic [15:0] EXPOSURE_RESET  = 16'h0100;
    localparam logic [7:0]  PRELOAD_RESET   = 8'hC2;

    // Pixel readout field positions
    localparam int          SOF_BIT         = 7;
    localparam int          VALID_BIT       = 6;
    localparam logic [5:0]  PIXEL_MAX_VAL   = 6'h3F;

    // Array geometry, numbered column by column
    localparam int          ARRAY_ROWS      = 18;
    localparam int          ARRAY_COLS      = 18;
    localparam logic [8:0]  NUM_PIXELS     = 9'(ARRAY_ROWS * ARRAY_COLS);
    localparam logic [8:0]  FIRST_PIXEL     = 9'h001;

    // Exposure control window on brightest pixel (mid fifties)
    localparam logic [5:0]  AGC_HIGH        = 6'h39;
    localparam logic [5:0]  AGC_LOW         = 6'h34;
    localparam int          AGC_SHIFT       = 4;
    localparam logic [16:0] EXP_MARGIN      = 17'h00D94;
    localparam logic [15:0] EXP_FLOOR       = 16'h0010;

    // Frame counter
    localparam logic [15:0] FRAME_TOP       = 16'hFFFF;
    localparam logic [16:0] FRAME_SPAN      = 17'h10000;

    // Sleep timing
    localparam int          CLK_HZ          = 20000000;
    localparam int          SLEEP_TIME_MS   = 1000;
    localparam int          SLEEP_CYCLES    = (CLK_HZ / 1000) * SLEEP_TIME_MS;

    // Stream buffer
    localparam int          STREAM_DEPTH    = 8;

    // One pixel word from the imaging array
    typedef struct packed {
        logic       first;
        logic [5:0] level;
    } pix_word_s;

    // Grabber states
    typedef enum logic [1:0] {
        GRAB_IDLE,
        GRAB_WAIT_SOF,
        GRAB_SEEK,
        GRAB_HOLD
    } grab_state_e;

endpackage

/* sim/pix_array_model.sv */
// Purpose: imaging array stand-in feeding the grabber stream
// Assumes: frames of 324 words, word n carries (5n+3) mod 64
// Notes  : gap idles the stream; idle data toggles, never stale
module pix_array_model
    import pixgrab_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic       ready,
    input  wire logic       gap,
    output logic            valid,
    output logic            first,
    output logic [5:0]      data
);
    int n; // Number of the next word

    // Word held until taken, so a full FIFO stalls the frame
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valid <= 1'b0;
            first <= 1'b0;
            data  <= 6'h2A;
            n     <= 1;
        end
        else if (!valid || ready)
        begin
            valid <= !gap;
            first <= (n == 1);
            data  <= gap ? ~data : 6'((5 * n + 3) % 64);
            if (!gap)
                n <= (n == NUM_PIXELS) ? 1 : n + 1;
        end
    end
endmodule // pix_array_model

/* sim/pixgrab_top_bench.sv */
// Purpose: self-checking bench for the pixel grabber block
// Assumes: one-cycle register strobes, sleep count cut to 50
// Notes  : pixel, exposure and frame figures come from integer models
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin errors++; \
    $display("[ERR] t=%0t got %0h exp %0h", $time, g, e); end end
module pixgrab_top_bench
    import pixgrab_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, rst_n, wr, rd, pv, pf, prdy, fa, mot, awake, fend, gap, slow;
    logic [7:0]  addr, wdata, rdata, d;
    logic [5:0]  pd;
    logic [15:0] shut;
    int errors = 0, num_checks = 0, want = 1, last = -1, fcnt = 0, cyc = 0;
    int seed = 32'hE5F1, old = 16'h0100, pend = 8'hC2, per = 16'h3E00;

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    pixgrab_top #(.SLEEP_COUNT(50), .FIFO_DEPTH(STREAM_DEPTH)) dut (
        .SYS_CLK(clk), .RESET_N(rst_n), .REG_ADDR(addr), .REG_WDATA(wdata),
        .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .PIX_VALID(pv),
        .PIX_FIRST(pf), .PIX_DATA(pd), .PIX_READY(prdy), .FORCED_AWAKE(fa),
        .MOTION(mot), .AWAKE(awake), .FRAME_END(fend), .SHUTTER(shut));
    pix_array_model array (.clk(clk), .rst_n(rst_n), .ready(prdy), .gap(gap),
        .valid(pv), .first(pf), .data(pd));

    // Random idle cycles in the stream once slow mode is on
    always @(posedge clk)
        gap <= slow && ($random(seed) % 3 == 0);

    // Frame period model: new preload applies from the next reload
    always @(posedge clk)
    begin
        cyc++;
        if (rst_n && fend === 1'b1)
        begin
            if (last >= 0)
                `CHK(cyc - last, per)
            last = cyc;
            per = 65536 - pend * 256;
            fcnt++;
        end
    end

    // Exposure model: steps of one sixteenth, floor, capped by frame
    always @(posedge clk)
        if (rst_n && shut != 16'(old))
        begin
            `CHK(shut == 16'(old - old / 16) || shut == 16'(old + old / 16)
                || shut == EXP_FLOOR, 1'b1)
            `CHK(int'(shut) <= per - 3476, 1'b1)
            old = shut;
        end

    ////////////////////////////////////////
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 v = rdata;
    endtask

    task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == ADDR_FRAME_PRE)
            pend = v;
    endtask

    task automatic conclude;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // Reads until count valid pixels came back; a hang is a mismatch
    task automatic grab(input int count);
        logic prev;
        prev = 1'b0;
        for (int i = 0; i < 9000 && count > 0; i++)
        begin
            rd_reg(ADDR_PIXEL, d);
            `CHK(d[SOF_BIT], want == 1)
            if (prev)
                `CHK(d[VALID_BIT], 1'b0)
            if (d[VALID_BIT] === 1'b1)
            begin
                `CHK(d[5:0], 6'((5 * want + 3) % 64))
                want = (want == 324) ? 1 : want + 1;
                count--;
            end
            prev = d[VALID_BIT];
        end
        if (count > 0)
            errors++;
    endtask

    task automatic wait_frames(input int n);
        for (int i = 0; i < 40000 && fcnt < n; i++)
            @(posedge clk);
        if (fcnt < n)
        begin
            errors++;
            conclude;
        end
    endtask

    ////////////////////////////////////////
    initial
    begin
        {rst_n, wr, rd, fa, mot, slow, gap, addr, wdata} = '0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        rd_reg(ADDR_EXP_HIGH, d);
        `CHK(d, EXPOSURE_RESET[15:8])
        rd_reg(ADDR_EXP_LOW, d);
        `CHK(d, EXPOSURE_RESET[7:0])
        rd_reg(ADDR_FRAME_PRE, d);
        `CHK(d, PRELOAD_RESET)
        wr_reg(ADDR_EXP_HIGH, 8'h5A);
        rd_reg(ADDR_EXP_HIGH, d);
        `CHK(d, 8'h01)
        rd_reg(8'h50, d);
        `CHK(d, 8'h00)
        $display("test registers done");
        repeat (60) @(posedge clk);
        `CHK(awake, 1'b0)
        mot <= 1'b1;
        @(posedge clk);
        mot <= 1'b0;
        fa <= 1'b1;
        repeat (80) @(posedge clk);
        `CHK(awake, 1'b1)
        $display("test sleep done");
        slow <= 1'b1;
        wr_reg(ADDR_PIXEL, 8'($random(seed)));
        repeat (1500) @(posedge clk);
        `CHK(prdy, 1'b0)
        grab(12);
        wr_reg(ADDR_PIXEL, 8'($random(seed)));
        want = 1;
        grab(3);
        $display("test pixel grab done");
        wait_frames(2);
        wr_reg(ADDR_FRAME_PRE, 8'hE0);
        rd_reg(ADDR_FRAME_PRE, d);
        `CHK(d, 8'hE0)
        wait_frames(4);
        $display("test frame timing done");
        conclude;
    end
endmodule // pixgrab_top_bench
